// file: sdc_pkg.sv
package sdc_pkg;
  // ==========================================
  // Memory map
  localparam logic [15:0] RAM_BASE = 16'h8000;
  localparam int RAM_BYTES = 6144;
  localparam int RAM_AW = 13;
  localparam logic [15:0] LOW_GUARD = 16'h0080;
  // ==========================================
  // Screen geometry
  localparam int SYS_SCREEN_BYTES = 640;
  localparam int GFX_COLS = 480;
  localparam int GFX_ROWS = 64;
  localparam int GFX_BYTES = GFX_COLS * GFX_ROWS / 8;
  localparam int FONT_W = 6;
  localparam int FONT_H = 7;
  localparam logic [7:0] USER_CHAR_FIRST = 8'he0;
  localparam int USER_CHAR_MAX = 32;
  localparam int CHAR_FLASH_MAX = 40;
  localparam int GFX_FLASH_DOTS_MAX = 144;
  localparam int FLASH_ENTRY_BYTES = 3;
  // ==========================================
  // Command codes
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_WRITE = 8'h01;
  localparam logic [7:0] CMD_EXEC = 8'h02;
  localparam logic [7:0] CMD_GFX_USER = 8'h20;
  localparam logic [7:0] CMD_GFX_FLASH = 8'h21;
  localparam logic [7:0] CMD_CHR_FLASH = 8'h31;
  localparam logic [7:0] CMD_HEAD_ON = 8'h41;
  localparam logic [7:0] CMD_HEAD_OFF = 8'h42;
  localparam logic [7:0] CMD_PLAY = 8'h48;
  localparam logic [7:0] CMD_MOTOR_STOP = 8'h4a;
  // ==========================================
  // Write operations and return codes
  localparam logic [7:0] OP_AND = 8'h01;
  localparam logic [7:0] OP_OR = 8'h02;
  localparam logic [7:0] OP_XOR = 8'h03;
  localparam logic [7:0] RC_NORMAL = 8'h00;
  localparam logic [7:0] RC_BAD_CMD = 8'h01;
  localparam logic [7:0] RC_BAD_MODE = 8'h02;
  // ==========================================
  // Host registers (AXI4-Lite byte offsets)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ARG = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_RESULT = 8'h0c;
  localparam int CTRL_GO_BIT = 0;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
endpackage : sdc_pkg

// file: sdc_link_if.sv
`timescale 1ns/1ns
interface sdc_link_if;
  // Byte stream host to device, then device to host
  logic [7:0] tx_data;
  logic tx_valid;
  logic tx_ready;
  logic [7:0] rx_data;
  logic rx_valid;
  logic rx_ready;
  modport device (
    input tx_data,
    input tx_valid,
    output tx_ready,
    output rx_data,
    output rx_valid,
    input rx_ready
  );
  modport host (
    output tx_data,
    output tx_valid,
    input tx_ready,
    input rx_data,
    input rx_valid,
    output rx_ready
  );
endinterface : sdc_link_if

// file: sdc_ram.sv
`timescale 1ns/1ns
module sdc_ram #(
  parameter int DEPTH = 6144,
  parameter int AW = 13
) (
  input wire logic aclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata,
  input wire logic [AW-1:0] vaddr,
  output logic [7:0] vdata
);
  // ==========================================
  // Battery-backed store, no reset by design
  logic [7:0] mem [0:DEPTH-1];

  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge aclk) begin
    rdata <= mem[raddr];
  end

  // Second port for the display fetch
  always_ff @(posedge aclk) begin
    vdata <= mem[vaddr];
  end
endmodule : sdc_ram

// file: sdc_device.sv
// The AXI4-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ns
module sdc_device #(
  parameter int RAM_DEPTH = sdc_pkg::RAM_BYTES
) (
  input wire logic aclk,
  input wire logic aresetn,
  sdc_link_if.device link,
  input wire logic gfx_mode,
  input wire logic [sdc_pkg::RAM_AW-1:0] fetch_addr,
  output logic [7:0] fetch_data,
  output logic [15:0] exec_addr,
  output logic exec_pulse,
  output logic [15:0] chr_flash_base,
  output logic [15:0] gfx_flash_base,
  output logic [15:0] gfx_user_base
);
  typedef enum logic [5:0] {
    ST_CMD = 6'b000001,
    ST_ARG = 6'b000010,
    ST_MEM = 6'b000100,
    ST_RC = 6'b001000,
    ST_RP = 6'b010000,
    ST_WR = 6'b100000
  } sdc_dev_st_t;

  localparam int AW = sdc_pkg::RAM_AW;
  sdc_dev_st_t st_r;
  logic [7:0] cmd_r;
  logic [2:0] cnt_r;
  logic [2:0] need;
  logic [15:0] addr_r;
  logic [7:0] data_r;
  logic [7:0] op_r;
  logic [7:0] rc_r;
  logic [7:0] rp_r;
  logic in_ram;
  logic [AW-1:0] ram_idx;
  logic [7:0] ram_q;
  logic [7:0] merged;
  logic ram_we;
  logic tx_take;
  logic rx_take;

  // ==========================================
  // Argument counts
  always_comb begin
    case (cmd_r)
      sdc_pkg::CMD_READ: need = 3'd2;
      sdc_pkg::CMD_WRITE: need = 3'd4;
      sdc_pkg::CMD_EXEC: need = 3'd2;
      sdc_pkg::CMD_GFX_USER: need = 3'd2;
      sdc_pkg::CMD_GFX_FLASH: need = 3'd2;
      sdc_pkg::CMD_CHR_FLASH: need = 3'd2;
      default: need = 3'd0;
    endcase
  end

  assign tx_take = link.tx_valid && link.tx_ready;
  assign rx_take = link.rx_valid && link.rx_ready;
  // Window outside 8000h..+6K reads as zero, writes dropped
  assign in_ram = addr_r >= sdc_pkg::RAM_BASE &&
    addr_r < sdc_pkg::RAM_BASE + 16'(RAM_DEPTH);
  assign ram_idx = AW'(addr_r - sdc_pkg::RAM_BASE);
  assign ram_we = st_r == ST_WR && in_ram;

  // ==========================================
  // Read-modify-write merge
  always_comb begin
    case (op_r)
      sdc_pkg::OP_AND: merged = ram_q & data_r;
      sdc_pkg::OP_OR: merged = ram_q | data_r;
      sdc_pkg::OP_XOR: merged = ram_q ^ data_r;
      default: merged = data_r;
    endcase
  end

  sdc_ram #(
    .DEPTH(RAM_DEPTH),
    .AW(AW)
  ) sdc_ram_inst (
    .aclk(aclk),
    .we(ram_we),
    .waddr(ram_idx),
    .wdata(merged),
    .raddr(ram_idx),
    .rdata(ram_q),
    .vaddr(fetch_addr),
    .vdata(fetch_data)
  );

  // ==========================================
  // Command sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= ST_CMD;
    end else begin
      case (st_r)
        ST_CMD: if (tx_take) st_r <= ST_ARG;
        ST_ARG: if (cnt_r == need) st_r <= ST_MEM;
        ST_MEM: begin
          if (cmd_r == sdc_pkg::CMD_WRITE) st_r <= ST_WR;
          else st_r <= ST_RC;
        end
        ST_WR: st_r <= ST_RC;
        ST_RC: begin
          if (rx_take) begin
            // Parameter only on success of a read
            if (cmd_r == sdc_pkg::CMD_READ && rc_r == 8'h00) begin
              st_r <= ST_RP;
            end else begin
              st_r <= ST_CMD;
            end
          end
        end
        ST_RP: if (rx_take) st_r <= ST_CMD;
        default: st_r <= ST_CMD;
      endcase
    end
  end

  // Arguments, high address byte first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_r <= 8'h00;
      cnt_r <= 3'd0;
      addr_r <= 16'h0000;
      data_r <= 8'h00;
      op_r <= 8'h00;
    end else if (st_r == ST_CMD && tx_take) begin
      cmd_r <= link.tx_data;
      cnt_r <= 3'd0;
    end else if (st_r == ST_ARG && tx_take && cnt_r != need) begin
      cnt_r <= cnt_r + 3'd1;
      case (cnt_r)
        3'd0: addr_r[15:8] <= link.tx_data;
        3'd1: addr_r[7:0] <= link.tx_data;
        3'd2: data_r <= link.tx_data;
        default: op_r <= link.tx_data;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.tx_ready <= 1'b0;
    end else begin
      link.tx_ready <= (st_r == ST_CMD || (st_r == ST_ARG && cnt_r != need))
        && !tx_take;
    end
  end

  // ==========================================
  // Return code and parameter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rc_r <= sdc_pkg::RC_NORMAL;
      rp_r <= 8'h00;
    end else if (st_r == ST_MEM) begin
      rp_r <= in_ram ? ram_q : 8'h00;
      case (cmd_r)
        sdc_pkg::CMD_READ, sdc_pkg::CMD_WRITE, sdc_pkg::CMD_EXEC,
        sdc_pkg::CMD_CHR_FLASH: rc_r <= sdc_pkg::RC_NORMAL;
        sdc_pkg::CMD_GFX_USER, sdc_pkg::CMD_GFX_FLASH: begin
          rc_r <= gfx_mode ? sdc_pkg::RC_NORMAL
            : sdc_pkg::RC_BAD_MODE;
        end
        default: rc_r <= sdc_pkg::RC_BAD_CMD;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.rx_valid <= 1'b0;
      link.rx_data <= 8'h00;
    end else if (st_r == ST_RC && !link.rx_valid) begin
      link.rx_valid <= 1'b1;
      link.rx_data <= rc_r;
    end else if (rx_take && st_r == ST_RC && cmd_r == sdc_pkg::CMD_READ
        && rc_r == 8'h00) begin
      link.rx_data <= rp_r;
    end else if (rx_take) begin
      link.rx_valid <= 1'b0;
    end
  end

  // ==========================================
  // Area bases and execute
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chr_flash_base <= 16'h0000;
      gfx_flash_base <= 16'h0000;
      gfx_user_base <= 16'h0000;
      exec_addr <= 16'h0000;
      exec_pulse <= 1'b0;
    end else begin
      exec_pulse <= 1'b0;
      if (st_r == ST_MEM) begin
        case (cmd_r)
          sdc_pkg::CMD_CHR_FLASH: chr_flash_base <= addr_r;
          sdc_pkg::CMD_GFX_FLASH: begin
            if (gfx_mode) gfx_flash_base <= addr_r;
          end
          sdc_pkg::CMD_GFX_USER: begin
            if (gfx_mode) gfx_user_base <= addr_r;
          end
          sdc_pkg::CMD_EXEC: begin
            exec_addr <= addr_r;
            exec_pulse <= 1'b1;
          end
          default: exec_pulse <= 1'b0;
        endcase
      end
    end
  end
endmodule : sdc_device

// file: sdc_host.sv
`timescale 1ns/1ns
module sdc_host (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  sdc_link_if.host link
);
  typedef enum logic [3:0] {
    HS_IDLE = 4'b0001,
    HS_SEND = 4'b0010,
    HS_RECV = 4'b0100,
    HS_DONE = 4'b1000
  } sdc_host_st_t;

  sdc_host_st_t st_r;
  logic [31:0] ctrl_r;
  logic [31:0] arg_r;
  logic [31:0] res_r;
  logic [2:0] idx_r;
  logic [2:0] slen;
  logic [1:0] rlen;
  logic [1:0] ridx_r;
  logic go;
  logic [7:0] awaddr_r;
  logic aw_have_r;
  logic w_have_r;
  logic [31:0] wdata_r;

  // ==========================================
  // Write channel, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sdc_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        wdata_r <= s_axi_wdata;
      end
      if (aw_have_r && w_have_r && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_r == sdc_pkg::REG_CTRL ||
          awaddr_r == sdc_pkg::REG_ARG) ? sdc_pkg::RESP_OKAY
          : sdc_pkg::RESP_SLVERR;
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
    end
  end

  assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready = !w_have_r && !s_axi_bvalid;
  assign go = aw_have_r && w_have_r && !s_axi_bvalid &&
    awaddr_r == sdc_pkg::REG_CTRL && wdata_r[sdc_pkg::CTRL_GO_BIT];

  // Orders while busy are ignored so commands never overlap
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= 32'h0000_0000;
      arg_r <= 32'h0000_0000;
    end else if (aw_have_r && w_have_r && !s_axi_bvalid &&
        st_r != HS_SEND && st_r != HS_RECV) begin
      if (awaddr_r == sdc_pkg::REG_CTRL) ctrl_r <= wdata_r;
      if (awaddr_r == sdc_pkg::REG_ARG) arg_r <= wdata_r;
    end
  end

  // ==========================================
  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= sdc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= sdc_pkg::RESP_OKAY;
      case (s_axi_araddr)
        sdc_pkg::REG_CTRL: s_axi_rdata <= ctrl_r;
        sdc_pkg::REG_ARG: s_axi_rdata <= arg_r;
        sdc_pkg::REG_STATUS: s_axi_rdata <= {30'h0000_0000,
          st_r == HS_DONE, st_r == HS_SEND || st_r == HS_RECV};
        sdc_pkg::REG_RESULT: s_axi_rdata <= res_r;
        default: begin
          s_axi_rdata <= sdc_pkg::ZERO32;
          s_axi_rresp <= sdc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  // ==========================================
  // Packet lengths from command
  always_comb begin
    case (ctrl_r[15:8])
      sdc_pkg::CMD_READ: slen = 3'd3;
      sdc_pkg::CMD_WRITE: slen = 3'd5;
      sdc_pkg::CMD_EXEC, sdc_pkg::CMD_GFX_USER, sdc_pkg::CMD_GFX_FLASH,
      sdc_pkg::CMD_CHR_FLASH: slen = 3'd3;
      default: slen = 3'd1;
    endcase
    rlen = (ctrl_r[15:8] == sdc_pkg::CMD_READ) ? 2'd2 : 2'd1;
  end

  // ==========================================
  // Packet engine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= HS_IDLE;
      idx_r <= 3'd0;
      ridx_r <= 2'd0;
      res_r <= 32'h0000_0000;
    end else begin
      case (st_r)
        HS_IDLE, HS_DONE: begin
          if (go) begin
            st_r <= HS_SEND;
            idx_r <= 3'd0;
            ridx_r <= 2'd0;
          end
        end
        HS_SEND: begin
          if (link.tx_valid && link.tx_ready) begin
            idx_r <= idx_r + 3'd1;
            if (idx_r + 3'd1 == slen) st_r <= HS_RECV;
          end
        end
        HS_RECV: begin
          if (link.rx_valid && link.rx_ready) begin
            ridx_r <= ridx_r + 2'd1;
            if (ridx_r == 2'd0) begin
              res_r <= {24'h00_0000, link.rx_data};
              if (link.rx_data != 8'h00 || rlen == 2'd1) begin
                st_r <= HS_DONE;
              end
            end else begin
              res_r[15:8] <= link.rx_data;
              st_r <= HS_DONE;
            end
          end
        end
        default: st_r <= HS_IDLE;
      endcase
    end
  end

  // Byte order: cmd, addr high, addr low, data, op
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.tx_valid <= 1'b0;
      link.tx_data <= 8'h00;
      link.rx_ready <= 1'b0;
    end else begin
      link.rx_ready <= st_r == HS_RECV;
      if (st_r == HS_SEND && (!link.tx_valid || link.tx_ready)) begin
        if (link.tx_valid && idx_r + 3'd1 == slen) begin
          link.tx_valid <= 1'b0;
        end else begin
          link.tx_valid <= 1'b1;
          case (link.tx_valid ? idx_r + 3'd1 : idx_r)
            3'd0: link.tx_data <= ctrl_r[15:8];
            3'd1: link.tx_data <= arg_r[15:8];
            3'd2: link.tx_data <= arg_r[7:0];
            3'd3: link.tx_data <= arg_r[23:16];
            default: link.tx_data <= arg_r[31:24];
          endcase
        end
      end else if (st_r != HS_SEND) begin
        link.tx_valid <= 1'b0;
      end
    end
  end
endmodule : sdc_host

// file: sdc_link_monitor.sv
`timescale 1ns/1ns
module sdc_link_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_ready
);
  // ==========================================
  // Packet tracking
  logic tx_hs, rx_hs, rc_hs, last_tx, start_r, rxd_r, rw_cmd;
  logic [7:0] cmd_r;
  logic [2:0] cnt_r;
  function automatic logic [2:0] nargs(input logic [7:0] c);
    case (c)
      sdc_pkg::CMD_WRITE: return 3'h4;
      sdc_pkg::CMD_READ, sdc_pkg::CMD_EXEC, sdc_pkg::CMD_GFX_USER,
      sdc_pkg::CMD_GFX_FLASH, sdc_pkg::CMD_CHR_FLASH: return 3'h2;
      default: return 3'h0;
    endcase
  endfunction : nargs
  assign tx_hs = tx_valid && tx_ready;
  assign rx_hs = rx_valid && rx_ready;
  // First answer byte after a packet is the return code
  assign rc_hs = rx_hs && !rxd_r;
  assign rw_cmd = cmd_r == sdc_pkg::CMD_READ || cmd_r == sdc_pkg::CMD_WRITE;
  assign last_tx = tx_hs && (start_r ? nargs(tx_data) == 3'h0
                                     : cnt_r == nargs(cmd_r));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_r <= 1'b1;
      rxd_r <= 1'b0;
    end else if (tx_hs) begin
      start_r <= 1'b0;
      rxd_r <= 1'b0;
    end else if (rx_hs) begin
      start_r <= 1'b1;
      rxd_r <= 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_r <= 8'h00;
      cnt_r <= 3'h0;
    end else if (tx_hs && start_r) begin
      cmd_r <= tx_data;
      cnt_r <= 3'h1;
    end else if (tx_hs) begin
      cnt_r <= cnt_r + 3'h1;
    end
  end
  // ==========================================
  // Link properties
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_tx_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("tx byte dropped before taken");
  property p_rx_hold;
    rx_valid && !rx_ready |=> rx_valid && $stable(rx_data);
  endproperty
  a_rx_hold: assert property (p_rx_hold)
    else $error("rx byte dropped before taken");
  property p_take_gap;
    tx_hs |=> !tx_ready;
  endproperty
  a_take_gap: assert property (p_take_gap)
    else $error("tx_ready not lowered after take");
  property p_one_at_time;
    rx_valid |-> !tx_valid;
  endproperty
  a_one_at_time: assert property (p_one_at_time)
    else $error("new byte offered during answer");
  property p_no_early;
    tx_hs && !last_tx |=> !rx_valid;
  endproperty
  a_no_early: assert property (p_no_early)
    else $error("answer before packet complete");
  property p_answer;
    last_tx |-> ##[1:16] rx_valid;
  endproperty
  a_answer: assert property (p_answer)
    else $error("no return code after packet");
  property p_err_quiet;
    rc_hs && rx_data != sdc_pkg::RC_NORMAL |=> !rx_valid;
  endproperty
  a_err_quiet: assert property (p_err_quiet)
    else $error("parameter after error code");
  property p_read_byte;
    rc_hs && rx_data == sdc_pkg::RC_NORMAL && cmd_r == sdc_pkg::CMD_READ
      |=> rx_valid;
  endproperty
  a_read_byte: assert property (p_read_byte)
    else $error("read byte missing");
  property p_rc_zero;
    rc_hs && rw_cmd |-> rx_data == sdc_pkg::RC_NORMAL;
  endproperty
  a_rc_zero: assert property (p_rc_zero)
    else $error("read or write code not zero");
  property p_addr_high;
    tx_hs && !start_r && cnt_r == 3'h1 && rw_cmd |-> tx_data[7:5] == 3'h4;
  endproperty
  a_addr_high: assert property (p_addr_high)
    else $error("address low byte sent first");
endmodule : sdc_link_monitor

// file: slave_display_command_processor_bench.sv
`timescale 1ns/1ns
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value at %0t: %h vs %h", $time, g, e); end end
module slave_display_command_processor_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic gfx_mode = 1'b0;
  logic [sdc_pkg::RAM_AW-1:0] fetch_addr = 13'h0000;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, exec_pulse;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0] fetch_data;
  logic [15:0] exec_addr, chr_flash_base, gfx_flash_base, gfx_user_base;
  int mismatches = 0;
  int cmp_count = 0;
  integer seed = 62780;
  typedef struct packed {logic [31:0] d; logic [31:0] m;
    logic [1:0] r;} sdc_rexp_t;
  sdc_rexp_t rq[$];
  logic [1:0] bq[$];
  logic [15:0] xq[$];
  logic [7:0] fq[$];
  logic fetch_go = 1'b0, fetch_go_d = 1'b0;
  sdc_link_if link ();
  sdc_host sdc_host_inst (.*);
  sdc_device sdc_device_inst (.*);
  sdc_link_monitor sdc_link_monitor_inst (.aclk(aclk), .aresetn(aresetn),
    .tx_data(link.tx_data), .tx_valid(link.tx_valid),
    .tx_ready(link.tx_ready), .rx_data(link.rx_data),
    .rx_valid(link.rx_valid), .rx_ready(link.rx_ready));
  initial begin
    forever #25 aclk = ~aclk;
  end
  // ==========================================
  // Bus tasks
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    @(posedge aclk);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, input sdc_rexp_t e,
                        output logic [31:0] d);
    @(posedge aclk);
    rq.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  // One whole command; e holds read byte and return code, m their mask
  task automatic run(input logic [7:0] c, input logic [31:0] arg,
                     input logic [15:0] e, input logic [15:0] m);
    logic [31:0] st;
    int n;
    axi_wr(sdc_pkg::REG_ARG, arg, sdc_pkg::RESP_OKAY);
    axi_wr(sdc_pkg::REG_CTRL, {16'h0000, c, 8'h01}, sdc_pkg::RESP_OKAY);
    st = 32'h0000_0000;
    n = 0;
    while (!(st[1] === 1'b1 && st[0] === 1'b0) && n < 200) begin
      axi_rd(sdc_pkg::REG_STATUS, '{32'h0000_0000, 32'h0000_0000,
             sdc_pkg::RESP_OKAY}, st);
      n++;
    end
    if (st[1] !== 1'b1 || st[0] !== 1'b0) mismatches++;
    axi_rd(sdc_pkg::REG_RESULT, '{{16'h0000, e}, {16'h0000, m},
           sdc_pkg::RESP_OKAY}, st);
    // Argument word must survive the whole command unchanged
    axi_rd(sdc_pkg::REG_ARG, '{arg, 32'hffff_ffff, sdc_pkg::RESP_OKAY},
           st);
  endtask : run
  task automatic conclude();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude
  // ==========================================
  // Result watcher
  always @(posedge aclk) begin
    sdc_rexp_t e;
    logic [1:0] b;
    logic [15:0] x;
    logic [7:0] f;
    if (s_axi_rvalid && s_axi_rready) begin
      e = rq.pop_front();
      `CHK(s_axi_rdata & e.m, e.d & e.m)
      `CHK(s_axi_rresp, e.r)
    end
    if (s_axi_bvalid && s_axi_bready) begin
      b = bq.pop_front();
      `CHK(s_axi_bresp, b)
    end
    if (exec_pulse) begin
      x = xq.pop_front();
      `CHK(exec_addr, x)
    end
    if (fetch_go_d) begin
      f = fq.pop_front();
      `CHK(fetch_data, f)
    end
    fetch_go_d <= fetch_go;
  end
  initial begin
    repeat (40000) @(posedge aclk);
    mismatches++;
    conclude();
  end
  // ==========================================
  // Scenarios
  initial begin
    logic [31:0] d;
    logic [15:0] a;
    logic [15:0] bexp [3];
    logic [7:0] v, m, rc;
    logic [15:0] nok;
    logic [7:0] ops [5];
    logic [7:0] area [3];
    ops = '{8'h00, sdc_pkg::OP_AND, sdc_pkg::OP_OR, sdc_pkg::OP_XOR, 8'h7e};
    area = '{sdc_pkg::CMD_CHR_FLASH, sdc_pkg::CMD_GFX_FLASH,
             sdc_pkg::CMD_GFX_USER};
    bexp = '{16'h0000, 16'h0000, 16'h0000};
    m = 8'h00;
    // Tape codes are not decoded here, so they come back as unknown
    nok = {8'h00, sdc_pkg::RC_BAD_CMD};
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    axi_wr(8'h40, 32'h0000_0001, sdc_pkg::RESP_SLVERR);
    axi_rd(8'h44, '{32'h0000_0000, 32'hffff_ffff, sdc_pkg::RESP_SLVERR}, d);
    for (int k = 0; k < 3; k++) begin
      d = $random(seed);
      a = (k == 0) ? 16'h8000 : (k == 1) ? 16'h97ff : {4'h8, d[11:0]};
      for (int j = 0; j < 5; j++) begin
        d = $random(seed);
        v = d[7:0];
        case (ops[j])
          sdc_pkg::OP_AND: m = m & v;
          sdc_pkg::OP_OR: m = m | v;
          sdc_pkg::OP_XOR: m = m ^ v;
          default: m = v;
        endcase
        run(sdc_pkg::CMD_WRITE, {ops[j], v, a}, 16'h0000, 16'h00ff);
        run(sdc_pkg::CMD_READ, {16'h0000, a}, {m, 8'h00}, 16'hffff);
      end
      @(posedge aclk);
      fetch_addr <= a[sdc_pkg::RAM_AW-1:0];
      fetch_go <= 1'b1;
      fq.push_back(m);
      @(posedge aclk);
      fetch_go <= 1'b0;
    end
    // Past the top of the RAM: writes dropped, reads give zero
    run(sdc_pkg::CMD_WRITE, 32'h00a5_9800, 16'h0000, 16'h00ff);
    run(sdc_pkg::CMD_READ, 32'h0000_9800, 16'h0000, 16'hffff);
    xq.push_back(16'h9234);
    run(sdc_pkg::CMD_EXEC, 32'h0000_9234, 16'h0000, 16'h00ff);
    for (int g = 0; g < 2; g++) begin
      gfx_mode <= g[0];
      for (int k = 0; k < 3; k++) begin
        d = $random(seed);
        rc = (k > 0 && g == 0) ? sdc_pkg::RC_BAD_MODE : sdc_pkg::RC_NORMAL;
        run(area[k], {16'h0000, d[15:0]}, {8'h00, rc}, 16'h00ff);
        if (rc == sdc_pkg::RC_NORMAL) bexp[k] = d[15:0];
        `CHK(chr_flash_base, bexp[0])
        `CHK(gfx_flash_base, bexp[1])
        `CHK(gfx_user_base, bexp[2])
      end
    end
    // Tape stop, head off, then head on and play
    run(sdc_pkg::CMD_MOTOR_STOP, 32'h0000_0000, nok, 16'h00ff);
    run(sdc_pkg::CMD_HEAD_OFF, 32'h0000_0000, nok, 16'h00ff);
    run(sdc_pkg::CMD_HEAD_ON, 32'h0000_0000, nok, 16'h00ff);
    run(sdc_pkg::CMD_PLAY, 32'h0000_0000, nok, 16'h00ff);
    run(8'h55, 32'h0000_0000, {8'h00, sdc_pkg::RC_BAD_CMD}, 16'h00ff);
    conclude();
  end
endmodule : slave_display_command_processor_bench
